// >>> dv/capture_line_model.sv
/* Capture signal source at the far side. Assumes: the bench sets the level. */
`timescale 1ns/1ps
module capture_line_model
(
	input  wire level_in,
	output wire capture_pin_out
);
	// Pin changes out of phase with the clock
	assign #7 capture_pin_out = level_in;
endmodule // capture_line_model

// >>> dv/enhanced_capture_pwm_unit_steer_monitor.sv
/* Checker of steering and mode outputs. Assumes: bound to the block, one clock domain. */
`timescale 1ns/1ps
module enhanced_capture_pwm_unit_steer_monitor
(
	input wire       ref_clk_in,
	input wire       arst_n_in,
	input wire [3:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire       reg_write_in,
	input wire       pwm_base_in,
	input wire       converter_enabled_in,
	input wire [3:0] steer_out,
	input wire [3:0] steer_oe_out,
	input wire       timer_reset_out,
	input wire       conversion_start_out,
	input wire [9:0] duty_value_out
);
	logic [7:0] ctl_reg;
	// Shadow of the mode control register
	always @(posedge ref_clk_in or negedge arst_n_in)
		if (!arst_n_in)
			ctl_reg <= 8'h00;
		else if (reg_write_in && reg_addr_in == 4'h0)
			ctl_reg <= reg_wdata_in;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	a_off_idle: assert property (ctl_reg[3:0] == 4'h0 |=> steer_oe_out == 4'h0)
		else $error("pins driven while off");
	a_cmp_pin_a: assert property (ctl_reg[3:2] == 2'b10 |=> steer_oe_out == 4'h1)
		else $error("compare drives wrong pins");
	a_single_pin: assert property (ctl_reg[7:6] == 2'b00 && ctl_reg[3:2] == 2'b11 |=> steer_oe_out == 4'h1)
		else $error("single output drives wrong pins");
	a_forward_pins: assert property (ctl_reg[7:6] == 2'b01 && ctl_reg[3:0] == 4'hc
		|=> steer_out == {$past(pwm_base_in), 3'b001}) else $error("forward bridge pins wrong");
	a_half_gap: assert property (ctl_reg[7:6] == 2'b10 && ctl_reg[3:0] == 4'hc
		|=> steer_oe_out == 4'h3 && !(steer_out[0] && steer_out[1])) else $error("half bridge overlap");
	a_dead_gap: assert property (ctl_reg[7:6] == 2'b10 && ctl_reg[3:0] == 4'hc && $changed(pwm_base_in)
		|=> steer_out[1:0] == 2'b00 [*2]) else $error("half bridge dead time missing");
	a_reverse_pins: assert property (ctl_reg[7:6] == 2'b11 && ctl_reg[3:0] == 4'hc
		|=> steer_out == {2'b01, $past(pwm_base_in), 1'b0}) else $error("reverse bridge pins wrong");
	a_duty_zero: assert property (ctl_reg[3:2] != 2'b11 |=> duty_value_out == 10'h000)
		else $error("duty outside pwm");
	a_special_event: assert property (conversion_start_out |-> timer_reset_out && $past(converter_enabled_in))
		else $error("conversion start without event");
endmodule // enhanced_capture_pwm_unit_steer_monitor
bind enhanced_capture_pwm_unit_mode_and_output_steering enhanced_capture_pwm_unit_steer_monitor mon(.*);

// >>> dv/tb_top.sv
/* Self-checking bench of the steering block. Assumes: design from hw/ and the capture model. */
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst_n, wr, rd, pwm, cap, cen;
	logic [3:0]  addr;
	logic [7:0]  wd, v;
	logic [15:0] tmr;
	wire  [7:0]  rdata;
	wire  [3:0]  so, soe;
	wire  [9:0]  duty;
	wire         tres, cst, irq, cpin;
	int          n_mismatch, check_count, n_tres, n_cst;
	enhanced_capture_pwm_unit_mode_and_output_steering dut(.ref_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
		.timer_value_in(tmr), .pwm_base_in(pwm), .capture_pin_in(cpin), .converter_enabled_in(cen),
		.steer_out(so), .steer_oe_out(soe), .timer_reset_out(tres), .conversion_start_out(cst),
		.duty_value_out(duty), .irq_out(irq));
	capture_line_model src(.level_in(cap), .capture_pin_out(cpin));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		n_tres += tres;
		n_cst += cst;
	end
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task pulse_cap(input int n);
		repeat (n)
		begin
			cap <= 1'b1;
			tick(6);
			cap <= 1'b0;
			tick(6);
		end
	endtask
	task t_duty;
		rd_reg(4'h0);
		chk("mode control reset", 8'h00, v);
		wr_reg(4'h1, 8'ha5);
		wr_reg(4'h0, 8'h3c);
		rd_reg(4'h0);
		chk("mode control", 8'h3c, v);
		rd_reg(4'hf);
		chk("unmapped", 8'h00, v);
		chk("pwm duty", 10'h297, duty);
		wr_reg(4'h0, 8'h3a);
		tick(2);
		chk("compare duty", 10'h000, duty);
		$display("duty test done");
	endtask
	task t_steer;
		logic [3:0] e, oe, inv;
		for (int m = 12; m < 16; m++)
			for (int s = 0; s < 4; s++)
				for (int p = 0; p < 2; p++)
				begin
					wr_reg(4'h0, {s[1:0], 2'b00, m[3:0]});
					pwm <= p[0];
					tick(4);
					oe = (s == 0) ? 4'h1 : (s == 2) ? 4'h3 : 4'hf;
					e = (s == 0) ? {3'b000, p[0]} : (s == 1) ? {p[0], 3'b001} :
						(s == 2) ? {2'b00, ~p[0], p[0]} : {2'b01, p[0], 1'b0};
					inv = (m == 13) ? 4'ha : (m == 14) ? 4'h5 : (m == 15) ? 4'hf : 4'h0;
					chk("steer enables", oe, soe);
					chk("steer pins", (e ^ inv) & oe, so & oe);
				end
		$display("steer test done");
	endtask
	task t_compare;
		logic [3:0] modes [6] = '{4'h8, 4'ha, 4'h9, 4'h2, 4'hb, 4'hb};
		logic       pins [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h2, 8'h10);
		wr_reg(4'h5, 8'h03);
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(4'h6, {7'h00, i < 4});
			cen <= (i < 5);
			wr_reg(4'h0, {4'h0, modes[i]});
			tmr <= 16'h0010;
			tick(1);
			tmr <= 16'h0000;
			tick(2);
			chk("compare pin", pins[i], so[0]);
			chk("match irq", i < 4, irq);
			rd_reg(4'h4);
			chk("match status", 1'b1, v[0]);
			wr_reg(4'h5, 8'h03);
			tick(1);
			chk("irq cleared", 1'b0, irq);
		end
		chk("timer resets", 2, n_tres);
		chk("conversions", 1, n_cst);
		$display("compare test done");
	endtask
	task t_capture;
		wr_reg(4'h0, 8'h04);
		tmr <= 16'h1234;
		cap <= 1'b1;
		tick(8);
		cap <= 1'b0;
		tick(8);
		rd_reg(4'h3);
		chk("capture on fall", 8'h34, v);
		rd_reg(4'h4);
		chk("capture status", 1'b1, v[1]);
		wr_reg(4'h0, 8'h00);
		tick(2);
		rd_reg(4'h3);
		chk("capture after off", 8'h00, v);
		wr_reg(4'h0, 8'h06);
		tmr <= 16'h1111;
		pulse_cap(3);
		rd_reg(4'h3);
		chk("no capture before fourth rise", 8'h00, v);
		tmr <= 16'h2256;
		pulse_cap(1);
		rd_reg(4'h3);
		chk("capture on fourth rise", 8'h56, v);
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h0, 8'h07);
		tmr <= 16'h3311;
		pulse_cap(15);
		rd_reg(4'h3);
		chk("no capture before sixteenth rise", 8'h00, v);
		tmr <= 16'h4478;
		pulse_cap(1);
		rd_reg(4'h3);
		chk("capture on sixteenth rise", 8'h78, v);
		wr_reg(4'h0, 8'h05);
		tmr <= 16'h0099;
		pulse_cap(1);
		rd_reg(4'h3);
		chk("capture on rise", 8'h99, v);
		$display("capture test done");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		{wr, rd, pwm, cap, cen} = 5'h00;
		addr = 4'h0;
		wd = 8'h00;
		tmr = 16'h0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_duty;
		t_steer;
		t_compare;
		t_capture;
		conclude;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude;
	end
endmodule // tb_top

// >>> hw/enhanced_capture_pwm_unit_mode_and_output_steering.v
/*
 * Mode decode and output steering of an enhanced capture/compare/PWM unit:
 * control register, duty value, compare match actions, capture latch,
 * PWM steering onto four pins with polarity and a small deadband.
 * Assumes: timer value, PWM base waveform and capture pin come from outside;
 * capture pin is asynchronous; register port strobes are one cycle long.
 */
// Summary of operation
// - Compare modes: pin a only, others released; off, reserved and capture modes release all pins
// - Steer 00: pin a modulated, b-d released
// - Steer 01: d modulated, a active, b c inactive
// - Steer 10: a b complementary with deadband
// - Steer 11: b modulated, c active, a d inactive
// - Duty is low byte and two LSBs
// - Mode 0000 switches off, resets internal state
// - Codes 0001, 0011 reserved, no behaviour
// - Mode 0010 toggles pin, flags on match
// - Mode 0100 captures on falling edge
// - Mode 1001 clears pin, flags on match
// - Mode 1010 flags only, pin unchanged
// - Mode 1011 flags, resets timer, starts conversion while converter_enabled_in is high
// - Mode 1100 all pins active high
`timescale 1ns/1ps
`include "enhanced_capture_pwm_unit_mode_map.vh"

module enhanced_capture_pwm_unit_mode_and_output_steering
(
	input  wire        ref_clk_in,
	input  wire        arst_n_in,
	input  wire [3:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_write_in,
	input  wire        reg_read_in,
	output reg  [7:0]  reg_rdata_out,
	input  wire [15:0] timer_value_in,
	input  wire        pwm_base_in,
	input  wire        capture_pin_in,
	input  wire        converter_enabled_in,
	output reg  [3:0]  steer_out,
	output reg  [3:0]  steer_oe_out,
	output reg         timer_reset_out,
	output reg         conversion_start_out,
	output reg  [9:0]  duty_value_out,
	output reg         irq_out
);

	reg  [7:0]  mode_control_reg;
	reg  [7:0]  duty_low_byte_reg;
	reg  [15:0] compare_reg;
	reg  [15:0] capture_reg;
	reg  [1:0]  irq_status_reg;
	reg  [1:0]  irq_enable_reg;
	reg         compare_pin_reg;
	reg  [2:0]  cap_sync_reg;
	reg         cap_level_reg;
	reg  [3:0]  prescale_reg;
	reg         match_seen_reg;
	reg         pwm_prev_reg;
	reg  [2:0]  dead_cnt_reg;
	reg  [7:0]  rdata_next;
	reg  [3:0]  steer_next;
	reg  [3:0]  oe_next;
	reg         cap_event;
	reg         compare_pin_next;
	reg  [2:0]  dead_cnt_next;

	wire [3:0] unit_mode_select    = mode_control_reg[`FLD_MODE_HI:`FLD_MODE_LO];
	wire [1:0] output_steer_config = mode_control_reg[`FLD_STEER_HI:`FLD_STEER_LO];
	wire [1:0] duty_lsb_bits       = mode_control_reg[`FLD_DUTY_LSB_HI:`FLD_DUTY_LSB_LO];
	wire       pwm_mode            = unit_mode_select[3] & unit_mode_select[2];
	wire       compare_mode        = unit_mode_select[3] & ~unit_mode_select[2]
	                                 | (unit_mode_select == `MODE_CMP_TOGGLE);
	wire       raw_match           = (timer_value_in == compare_reg);
	wire       unit_match_flag     = compare_mode & raw_match & ~match_seen_reg;
	wire       wr_mode             = reg_write_in & (reg_addr_in == `OFF_MODE_CONTROL);
	wire       wr_duty             = reg_write_in & (reg_addr_in == `OFF_DUTY_LOW_BYTE);
	wire       wr_compare          = reg_write_in & (reg_addr_in == `OFF_COMPARE_VALUE);
	wire       wr_irq_en           = reg_write_in & (reg_addr_in == `OFF_IRQ_ENABLE);
	wire       cap_stable          = (cap_sync_reg[2] == cap_sync_reg[1]);
	wire       cap_rise            = cap_stable & cap_sync_reg[1] & ~cap_level_reg;
	wire       cap_fall            = cap_stable & ~cap_sync_reg[1] & cap_level_reg;
	wire [1:0] irq_set             = {cap_event, unit_match_flag};
	wire [1:0] irq_clr             = (reg_write_in && reg_addr_in == `OFF_IRQ_CLEAR) ? reg_wdata_in[1:0] : 2'h0;
	wire [1:0] irq_status_next     = (irq_status_reg & ~irq_clr) | irq_set;
	wire [3:0] pol_invert          = {unit_mode_select[0] & ~unit_mode_select[1] | (&unit_mode_select[1:0]),
	                                  unit_mode_select[1],
	                                  unit_mode_select[0],
	                                  unit_mode_select[1]};
	wire       pwm_settled         = (pwm_base_in == pwm_prev_reg) & (dead_cnt_reg == 3'h0);
	wire [3:0] steer_pol;

	// Capture qualification, with the prescaler counting rising edges
	always @*
	begin
		cap_event = 1'b0;
		case (unit_mode_select)
			`MODE_CAP_FALL:   cap_event = cap_fall;
			`MODE_CAP_RISE:   cap_event = cap_rise;
			`MODE_CAP_RISE4:  cap_event = cap_rise & (prescale_reg[1:0] == 2'h3);
			`MODE_CAP_RISE16: cap_event = cap_rise & (prescale_reg == 4'hf);
			default:          cap_event = 1'b0;
		endcase
	end

	// Pin action of the compare modes on a fresh match
	always @*
	begin
		compare_pin_next = compare_pin_reg;
		if (unit_match_flag)
		begin
			case (unit_mode_select)
				`MODE_CMP_TOGGLE: compare_pin_next = ~compare_pin_reg;
				`MODE_CMP_SET:    compare_pin_next = 1'b1;
				`MODE_CMP_CLEAR:  compare_pin_next = 1'b0;
				default:          compare_pin_next = compare_pin_reg;
			endcase
		end
	end

	// Dead time: the edge cycle itself is the first of the both-low cycles
	always @*
	begin
		if (pwm_base_in != pwm_prev_reg)
			dead_cnt_next = `DEADBAND_CYCLES - 3'h1;
		else if (dead_cnt_reg != 3'h0)
			dead_cnt_next = dead_cnt_reg - 3'h1;
		else
			dead_cnt_next = 3'h0;
	end

	// Pin steering: bit0 = a, 1 = b, 2 = c, 3 = d; polarity applied after
	always @*
	begin
		steer_next = 4'h0;
		oe_next    = 4'h0;
		if (!pwm_mode)
		begin
			steer_next = {3'h0, compare_pin_reg};
			oe_next    = (unit_mode_select[3] | unit_mode_select == `MODE_CMP_TOGGLE) ? 4'h1 : 4'h0;
		end
		else
		begin
			case (output_steer_config)
				`STEER_SINGLE:
				begin
					steer_next = {3'h0, pwm_base_in};
					oe_next    = 4'h1;
				end
				`STEER_FULL_FWD:
				begin
					steer_next = {pwm_base_in, 2'h0, 1'b1};
					oe_next    = 4'hf;
				end
				`STEER_HALF:
				begin
					steer_next = {2'h0, ~pwm_base_in & pwm_settled,
					              pwm_base_in & pwm_settled};
					oe_next    = 4'h3;
				end
				default:
				begin
					steer_next = {1'b0, 1'b1, pwm_base_in, 1'b0};
					oe_next    = 4'hf;
				end
			endcase
		end
	end

	// Polarity per pin; mode 1100 inverts nothing, only driven pins are inverted
	genvar pin;
	generate
		for (pin = 0; pin < 4; pin = pin + 1)
		begin : gen_pin_polarity
			assign steer_pol[pin] = steer_next[pin] ^ (pwm_mode & pol_invert[pin] & oe_next[pin]);
		end
	endgenerate

	// Read data for the cycle after the read strobe
	always @*
	begin
		case (reg_addr_in)
			`OFF_MODE_CONTROL:  rdata_next = mode_control_reg;
			`OFF_DUTY_LOW_BYTE: rdata_next = duty_low_byte_reg;
			`OFF_COMPARE_VALUE: rdata_next = compare_reg[7:0];
			`OFF_CAPTURE_VALUE: rdata_next = capture_reg[7:0];
			`OFF_IRQ_STATUS:    rdata_next = {6'h0, irq_status_reg};
			`OFF_IRQ_ENABLE:    rdata_next = {6'h0, irq_enable_reg};
			`OFF_UNIT_STATUS:   rdata_next = {7'h0, compare_pin_reg};
			default:            rdata_next = 8'h00;
		endcase
	end

	// Three-stage pin synchroniser; a change counts once stages two and three agree
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cap_sync_reg <= 3'h0;
			cap_level_reg <= 1'b0;
		end
		else
		begin
			cap_sync_reg <= {cap_sync_reg[1:0], capture_pin_in};
			if (cap_stable)
				cap_level_reg <= cap_sync_reg[1];
		end
	end

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			mode_control_reg <= `MODE_CONTROL_RST;
			duty_low_byte_reg <= 8'h00;
			compare_reg <= 16'h0000;
			irq_enable_reg <= 2'h0;
			reg_rdata_out <= 8'h00;
		end
		else
		begin
			reg_rdata_out <= reg_read_in ? rdata_next : 8'h00;
			if (wr_mode)
				mode_control_reg <= reg_wdata_in;
			if (wr_duty)
				duty_low_byte_reg <= reg_wdata_in;
			// Compare value shifts in one byte per write, high byte first
			if (wr_compare)
				compare_reg <= {compare_reg[7:0], reg_wdata_in};
			if (wr_irq_en)
				irq_enable_reg <= reg_wdata_in[1:0];
		end
	end

	// Unit internal state; held in reset while the mode is off
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			capture_reg <= 16'h0000;
			compare_pin_reg <= 1'b0;
			prescale_reg <= 4'h0;
			match_seen_reg <= 1'b0;
			pwm_prev_reg <= 1'b0;
			dead_cnt_reg <= 3'h0;
			timer_reset_out <= 1'b0;
			conversion_start_out <= 1'b0;
			duty_value_out <= 10'h000;
			steer_out <= 4'h0;
			steer_oe_out <= 4'h0;
		end
		else if (unit_mode_select == `MODE_OFF)
		begin
			capture_reg <= 16'h0000;
			compare_pin_reg <= 1'b0;
			prescale_reg <= 4'h0;
			match_seen_reg <= 1'b0;
			pwm_prev_reg <= 1'b0;
			dead_cnt_reg <= 3'h0;
			timer_reset_out <= 1'b0;
			conversion_start_out <= 1'b0;
			duty_value_out <= 10'h000;
			steer_out <= 4'h0;
			steer_oe_out <= 4'h0;
		end
		else
		begin
			match_seen_reg <= compare_mode & raw_match;
			if (cap_rise)
				prescale_reg <= prescale_reg + 4'h1;
			if (cap_event)
				capture_reg <= timer_value_in;
			compare_pin_reg <= compare_pin_next;
			timer_reset_out <= unit_match_flag & (unit_mode_select == `MODE_CMP_SPECIAL);
			conversion_start_out <= unit_match_flag & (unit_mode_select == `MODE_CMP_SPECIAL)
			                        & converter_enabled_in;
			duty_value_out <= pwm_mode ? {duty_low_byte_reg, duty_lsb_bits} : 10'h000;
			pwm_prev_reg <= pwm_base_in;
			dead_cnt_reg <= dead_cnt_next;
			steer_out <= steer_pol;
			steer_oe_out <= oe_next;
		end
	end

	// Sticky events: set wins over a simultaneous clear
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			irq_status_reg <= 2'h0;
			irq_out <= 1'b0;
		end
		else
		begin
			irq_status_reg <= irq_status_next;
			irq_out <= |(irq_status_next & irq_enable_reg);
		end
	end

endmodule // enhanced_capture_pwm_unit_mode_and_output_steering

// >>> hw/enhanced_capture_pwm_unit_mode_map.vh
/*
 * Register offsets, field positions, reset values and mode codes of the
 * enhanced capture/compare/PWM mode and steering block.
 * Assumes: included by the block's design file only.
 */
`ifndef ENHANCED_CAPTURE_PWM_UNIT_MODE_MAP_VH
`define ENHANCED_CAPTURE_PWM_UNIT_MODE_MAP_VH

`define ADDR_W              4
`define OFF_MODE_CONTROL    4'h0
`define OFF_DUTY_LOW_BYTE   4'h1
`define OFF_COMPARE_VALUE   4'h2
`define OFF_CAPTURE_VALUE   4'h3
`define OFF_IRQ_STATUS      4'h4
`define OFF_IRQ_CLEAR       4'h5
`define OFF_IRQ_ENABLE      4'h6
`define OFF_UNIT_STATUS     4'h7

`define MODE_CONTROL_RST    8'h00
`define FLD_STEER_HI        7
`define FLD_STEER_LO        6
`define FLD_DUTY_LSB_HI     5
`define FLD_DUTY_LSB_LO     4
`define FLD_MODE_HI         3
`define FLD_MODE_LO         0

`define MODE_OFF            4'h0
`define MODE_RSVD_A         4'h1
`define MODE_CMP_TOGGLE     4'h2
`define MODE_RSVD_B         4'h3
`define MODE_CAP_FALL       4'h4
`define MODE_CAP_RISE       4'h5
`define MODE_CAP_RISE4      4'h6
`define MODE_CAP_RISE16     4'h7
`define MODE_CMP_SET        4'h8
`define MODE_CMP_CLEAR      4'h9
`define MODE_CMP_SOFT       4'ha
`define MODE_CMP_SPECIAL    4'hb

`define STEER_SINGLE        2'h0
`define STEER_FULL_FWD      2'h1
`define STEER_HALF          2'h2
`define STEER_FULL_REV      2'h3

`define DEADBAND_CYCLES     3'h2

`define IRQ_BIT_MATCH       0
`define IRQ_BIT_CAPTURE     1

`endif
